// >>> serial_master_frame_formats.sv
// Purpose: framing and transfer modes of a synchronous serial master
// Assumes: link_clk runs one half serial clock per cycle; rxd is timed by it
// Notes: transmit words and received words cross by toggle handshakes
`timescale 1ns/10ps
module serial_master_frame_formats
   import serial_frame_pkg::*;
#(
   parameter int MAX_W = 32
)
(
   input logic clk,
   input logic rst_n,
   input logic link_clk,
   input logic [31:0] control_register_zero,
   input logic [1:0] three_wire_control_reg,
   input logic [15:0] frame_count_reg,
   input logic enable,
   input logic slave_enable,
   input logic [MAX_W-1:0] tx_data,
   input logic tx_valid,
   output logic tx_ready,
   output logic [MAX_W-1:0] rx_data,
   output logic rx_valid,
   output logic busy,
   output logic sclk_out,
   output logic ss_n,
   output logic txd,
   input logic rxd
);
   // clamp the frame length field to the supported range
   function automatic logic [4:0] clamp_len(input logic [4:0] f);
      logic [4:0] m;
      m = 5'(MAX_W - 1);
      if (f < MIN_LEN_M1)
         return MIN_LEN_M1;
      return (f > m) ? m : f;
   endfunction

   // place a word so that its top bit sits at bit 31
   function automatic logic [31:0] align_word(input logic [31:0] w, input logic [4:0] m1);
      return w << (5'h1F - m1);
   endfunction

   // system domain
   logic [MAX_W-1:0] tx_hold_r;
   logic [MAX_W-1:0] rx_data_r;
   logic req_r, ack_s1_r, ack_s2_r, tx_ready_r;
   logic rxt_s1_r, rxt_s2_r, rxt_s3_r, rx_valid_r;
   logic busy_s1_r, busy_s2_r, busy_r;
   // link domain
   link_state_t state_r, state_nxt;
   segment_t seg_r, seg_nxt;
   logic ph_r, ph_nxt, more_r, more_nxt, rxph_r, rxph_nxt;
   logic [4:0] bit_r, bit_nxt;
   logic [31:0] sh_r, sh_nxt, rx_r, rx_nxt, rxw_r;
   logic [15:0] cnt_r, cnt_nxt;
   logic ack_r, rxt_r, busy_l_r, sclk_r, ss_n_r, txd_r;
   logic take, push;
   logic [31:0] c0_s1_r, c0_r;
   logic [1:0] mw_s1_r, mw_r;
   logic [15:0] nf_s1_r, nf_r;
   logic en_s1_r, en_r, sel_s1_r, sel_r, req_s1_r, req_s2_r;

   // transmit handshake and receive edge in the system domain
   wire tx_load = tx_valid & tx_ready_r;
   wire req_nxt = req_r ^ tx_load;
   wire rx_edge = rxt_s2_r ^ rxt_s3_r;

   // system side: hold one transmit word, collect received words, busy
   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         tx_hold_r <= '0;
         req_r <= 1'h0;
         ack_s1_r <= 1'h0;
         ack_s2_r <= 1'h0;
         tx_ready_r <= 1'h0;
         rxt_s1_r <= 1'h0;
         rxt_s2_r <= 1'h0;
         rxt_s3_r <= 1'h0;
         rx_valid_r <= 1'h0;
         rx_data_r <= '0;
         busy_s1_r <= 1'h0;
         busy_s2_r <= 1'h0;
         busy_r <= 1'h0;
      end
      else
      begin
         if (tx_load)
            tx_hold_r <= tx_data;
         req_r <= req_nxt;
         ack_s1_r <= ack_r;
         ack_s2_r <= ack_s1_r;
         tx_ready_r <= (req_nxt == ack_s2_r);
         rxt_s1_r <= rxt_r;
         rxt_s2_r <= rxt_s1_r;
         rxt_s3_r <= rxt_s2_r;
         rx_valid_r <= rx_edge;
         if (rx_edge)
            rx_data_r <= rxw_r[MAX_W-1:0];
         busy_s1_r <= busy_l_r;
         busy_s2_r <= busy_s1_r;
         busy_r <= busy_s2_r | (req_r != ack_s2_r);
      end
   end

   // static control words synchronised into the link domain
   always_ff @(posedge link_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         {c0_s1_r, c0_r, mw_s1_r, mw_r, nf_s1_r, nf_r} <= '0;
         {en_s1_r, en_r, sel_s1_r, sel_r, req_s1_r, req_s2_r} <= '0;
      end
      else
      begin
         {c0_s1_r, mw_s1_r, nf_s1_r} <= {control_register_zero, three_wire_control_reg,
            frame_count_reg};
         {c0_r, mw_r, nf_r} <= {c0_s1_r, mw_s1_r, nf_s1_r};
         {en_s1_r, sel_s1_r, req_s1_r} <= {enable, slave_enable, req_r};
         {en_r, sel_r, req_s2_r} <= {en_s1_r, sel_s1_r, req_s1_r};
      end
   end

   // field decode
   wire [1:0] fmt_f = c0_r[CR0_FRF_LSB +: 2];
   wire [1:0] mode_f = c0_r[CR0_MODE_LSB +: 2];
   wire is_pulse = fmt_f == FMT_PULSE;
   wire is_tw = fmt_f == FMT_THREE_WIRE;
   wire is_spi = !is_pulse & !is_tw;
   wire pha_w = c0_r[CR0_PHASE_BIT];
   wire pol_w = c0_r[CR0_POL_BIT];
   wire ste_w = c0_r[CR0_TOGGLE_BIT];
   wire dir_w = mw_r[MW_DIR_BIT];
   wire seq_w = mw_r[MW_SEQ_BIT];
   wire m_txrx = mode_f == TM_TX_RX;
   wire m_rxo = mode_f == TM_RX_ONLY;
   wire m_mem = mode_f == TM_MEM_READ;
   wire [4:0] dlen_m1 = clamp_len(c0_r[CR0_DFS_LSB +: 5]);
   wire [4:0] clen_m1 = {1'h0, c0_r[CR0_CLEN_LSB +: 4]};
   wire [4:0] first_m1 = is_tw ? clen_m1 : dlen_m1;
   wire [31:0] tx_word = 32'(tx_hold_r);
   wire avail_w = req_s2_r ^ ack_r;
   wire start_w = en_r & sel_r & avail_w;
   // clock shape: idle level and which half carries the far level
   wire base_w = is_spi & pol_w;
   wire edge_w = is_pulse | (is_spi & pha_w);
   // frame counting, capture and continuation decisions
   wire tw_data = seg_r == SEG_DATA;
   wire counting_w = is_tw ? (tw_data & !dir_w & seq_w) : (m_rxo | (m_mem & rxph_r));
   wire cnt_done = cnt_r == nf_r;
   wire spi_cont = counting_w ? !cnt_done : (m_mem | avail_w);
   wire tw_cont = !tw_data | (counting_w ? !cnt_done : avail_w);
   wire cont_w = is_tw ? tw_cont : spi_cont;
   wire spi_cap = m_txrx | m_rxo | (m_mem & rxph_r);
   wire capture_w = is_tw ? (tw_data & !dir_w) : spi_cap;
   wire to_rx = rxph_r | (m_mem & !avail_w);
   wire [31:0] rx_mask = 32'hFFFF_FFFF >> (5'h1F - dlen_m1);

   // link sequencer: one cycle per half serial clock
   always_comb
   begin
      state_nxt = state_r;
      seg_nxt = seg_r;
      ph_nxt = ph_r;
      bit_nxt = bit_r;
      more_nxt = more_r;
      rxph_nxt = rxph_r;
      sh_nxt = sh_r;
      rx_nxt = rx_r;
      cnt_nxt = cnt_r;
      take = 1'h0;
      push = 1'h0;
      unique case (state_r)
         L_IDLE:
            if (start_w)
            begin
               take = 1'h1;
               state_nxt = L_LEAD;
               ph_nxt = 1'h0;
               more_nxt = 1'h0;
               cnt_nxt = '0;
               bit_nxt = first_m1;
               seg_nxt = is_tw ? SEG_CTRL : SEG_DATA;
               rxph_nxt = is_spi & m_rxo;
               // receive-only word is a dummy: output stays low
               sh_nxt = (!is_tw & m_rxo) ? '0 : align_word(tx_word, first_m1);
            end
         L_LEAD:
         begin
            ph_nxt = !ph_r;
            if (!is_pulse | ph_r)
            begin
               state_nxt = L_BITS;
               ph_nxt = 1'h0;
            end
         end
         L_BITS:
            if (!ph_r)
            begin
               ph_nxt = 1'h1;
               rx_nxt = {rx_r[30:0], rxd};
            end
            else
            begin
               ph_nxt = 1'h0;
               if (bit_r == 5'h1)
                  more_nxt = cont_w;
               if (bit_r != 5'h0)
               begin
                  bit_nxt = 5'(bit_r - 5'h1);
                  sh_nxt = sh_r << 1;
               end
               else
               begin
                  push = capture_w;
                  if (counting_w)
                     cnt_nxt = 16'(cnt_r + 16'h1);
                  if (is_tw)
                  begin
                     unique case (seg_r)
                        SEG_CTRL:
                           if (dir_w)
                           begin
                              // write data follows the control word at once
                              seg_nxt = SEG_DATA;
                              bit_nxt = dlen_m1;
                              take = avail_w;
                              sh_nxt = avail_w ? align_word(tx_word, dlen_m1) : '0;
                           end
                           else
                           begin
                              seg_nxt = SEG_DUMMY;
                              bit_nxt = 5'h0;
                              sh_nxt = '0;
                           end
                        SEG_DUMMY:
                        begin
                           seg_nxt = SEG_DATA;
                           bit_nxt = dlen_m1;
                        end
                        default:
                           if (!more_r)
                              state_nxt = L_TAIL;
                           else if (counting_w)
                              bit_nxt = dlen_m1;
                           else
                           begin
                              take = 1'h1;
                              seg_nxt = SEG_CTRL;
                              bit_nxt = clen_m1;
                              sh_nxt = align_word(tx_word, clen_m1);
                           end
                     endcase
                  end
                  else if (!more_r)
                     state_nxt = L_TAIL;
                  else
                  begin
                     if (to_rx)
                     begin
                        rxph_nxt = 1'h1;
                        sh_nxt = '0;
                     end
                     else
                     begin
                        take = 1'h1;
                        sh_nxt = align_word(tx_word, dlen_m1);
                     end
                     bit_nxt = dlen_m1;
                     if (is_spi & !pha_w & ste_w)
                        state_nxt = L_TAIL;
                  end
               end
            end
         L_TAIL:
         begin
            state_nxt = more_r ? L_GAP : L_IDLE;
            more_nxt = 1'h0;
         end
         L_GAP:
            state_nxt = L_LEAD;
         default:
            state_nxt = L_IDLE;
      endcase
      if (!en_r)
         state_nxt = L_IDLE;
   end

   // pin values for the coming half clock
   wire st_bits = state_nxt == L_BITS;
   wire st_lead = state_nxt == L_LEAD;
   wire in_frame = st_lead | st_bits | (state_nxt == L_TAIL);
   wire clk_run = st_bits | (st_lead & is_pulse);
   wire sclk_nxt = clk_run ? (base_w ^ ph_nxt ^ edge_w) : base_w;
   wire marker = st_lead | (st_bits & (bit_nxt == 5'h0) & more_nxt);
   wire ss_nxt = is_pulse ? marker : !in_frame;
   wire drive_w = st_bits | (st_lead & is_spi & !pha_w);
   wire txd_nxt = drive_w ? sh_nxt[31] : 1'h0;

   // link registers and pins
   always_ff @(posedge link_clk or negedge rst_n)
   begin
      if (!rst_n)
      begin
         state_r <= L_IDLE;
         seg_r <= SEG_DATA;
         {ph_r, more_r, rxph_r, ack_r, rxt_r, busy_l_r} <= '0;
         {bit_r, cnt_r, sh_r, rx_r, rxw_r} <= '0;
         sclk_r <= SCLK_RESET;
         ss_n_r <= SS_RESET;
         txd_r <= TXD_RESET;
      end
      else
      begin
         state_r <= state_nxt;
         seg_r <= seg_nxt;
         {ph_r, more_r, rxph_r, bit_r} <= {ph_nxt, more_nxt, rxph_nxt, bit_nxt};
         {sh_r, rx_r, cnt_r} <= {sh_nxt, rx_nxt, cnt_nxt};
         ack_r <= ack_r ^ take;
         if (push)
            rxw_r <= rx_r & rx_mask;
         rxt_r <= rxt_r ^ push;
         busy_l_r <= state_nxt != L_IDLE;
         {sclk_r, ss_n_r, txd_r} <= {sclk_nxt, ss_nxt, txd_nxt};
      end
   end

   assign tx_ready = tx_ready_r;
   assign rx_data = rx_data_r;
   assign rx_valid = rx_valid_r;
   assign busy = busy_r;
   assign sclk_out = sclk_r;
   assign ss_n = ss_n_r;
   assign txd = txd_r;

   // checks on the link side
   default clocking cb @(posedge link_clk);
   endclocking
   default disable iff (!rst_n);

   a_idle_clock_level:
      assert property (state_r == L_IDLE && is_spi && $stable(c0_r) |-> sclk_r == pol_w)
      else $error("idle clock level wrong");
   a_frame_len_range:
      assert property (state_r == L_BITS && seg_r == SEG_DATA
         |-> bit_r <= dlen_m1 && dlen_m1 >= MIN_LEN_M1)
      else $error("frame shorter than four bits");
   a_lead_first_bit:
      assert property (state_r == L_LEAD && is_spi && !pha_w
         |-> txd_r == sh_r[31] && !ss_n_r && sclk_r == pol_w)
      else $error("first bit not ready before first edge");
   a_toggle_gap:
      assert property (state_r == L_GAP |-> ss_n_r && sclk_r == pol_w ##1 !ss_n_r)
      else $error("select not toggled between frames");
   a_phase1_lead:
      assert property (state_r == L_BITS && is_spi && pha_w && !ph_r |-> sclk_r != pol_w)
      else $error("phase one leading edge missing");
   a_back_to_back:
      assert property (state_r == L_BITS && is_spi && pha_w && ph_r && bit_r == 5'h0
         && more_r && en_r |=> state_r == L_BITS && !ss_n_r && bit_r == dlen_m1)
      else $error("continuous frame broken");
   a_rx_push:
      assert property (state_r == L_BITS && ph_r && bit_r == 5'h0 && capture_w
         |=> rxt_r != $past(rxt_r))
      else $error("received frame not pushed");
   a_tx_only_drop:
      assert property (is_spi && mode_f == TM_TX_ONLY |=> $stable(rxt_r))
      else $error("transmit-only frame stored");
   a_rx_only_quiet:
      assert property (is_spi && m_rxo && $stable(c0_r) && state_r != L_IDLE |-> !txd_r)
      else $error("receive-only output not constant");
   a_pulse_width:
      assert property (is_pulse && state_r == L_LEAD && !ph_r
         |-> ss_n_r ##1 ss_n_r ##1 !ss_n_r)
      else $error("frame marker not one clock");
   a_pulse_on_last:
      assert property (is_pulse && state_r == L_BITS && ss_n_r |-> bit_r == 5'h0 && more_r)
      else $error("frame marker off the last bit");
   a_three_wire_lead:
      assert property (is_tw && state_r == L_LEAD
         |-> !ss_n_r && !txd_r && !sclk_r && bit_r == clen_m1 ##1 state_r != L_LEAD)
      else $error("control word lead wrong");
   a_select_held:
      assert property (is_tw && state_r == L_TAIL |-> !ss_n_r ##1 ss_n_r)
      else $error("select release wrong");
   a_count_cap:
      assert property (counting_w && state_r == L_BITS |-> cnt_r <= nf_r)
      else $error("frame count overrun");

   c_pulse_continuous: cover property (is_pulse && state_r == L_BITS && ss_n_r);
   c_select_toggle: cover property (state_r == L_GAP);
   c_seq_read_done: cover property (is_tw && counting_w && cnt_done && state_r == L_TAIL);
   c_mem_read_rx: cover property (m_mem && $rose(rxph_r));
endmodule // serial_master_frame_formats

// >>> serial_frame_pkg.sv
// Purpose: constants and types of the serial master framing block
// Assumes: control words are changed only while the link is idle
// Notes: field positions index the control words given as ports
// Overview of operation
// - spi idle clock level set by polarity, low in other formats; both ends share polarity and phase
// - spi frames run 4 bits up to the maximum frame width parameter
// - phase 0 starts at select fall; first bit valid before first clock edge
// - phase 0 with toggle set drops select between frames, clock held idle
// - phase 1 drives on leading edges, first sample on second edge
// - phase 1 continuous frames run back to back under one select
// - mode 00 shifts transmit words out and pushes every received frame
// - mode 01 transmits and discards all received bits
// - mode 10 takes one dummy word, holds output constant, stores frames
// - mode 11 sends opcode and address uncaptured, then stores read frames
// - pulse format marks frame for one clock; change rising, sample falling
// - pulse format frames run four to 32 bits
// - continuous pulse format pulses the marker during the last bit
// - three-wire drops select, first control bit half a clock later
// - three-wire control word is 1 to 16 bits from bits 15:12
// - direction bit 1 selects master write right after the control word
// - three-wire read data change on falling edge, sampled on rising edge
// - three-wire select stays low all transfer, released half clock after
// - nonsequential mode sends next control word right after data word
// - sequential read sends one control word, stops after count plus one
// - receive-only mode stops after frame count plus one frames
// - mode 11 stops after frame count plus one read frames; modes 00 and 01 stop and clear busy when the transmit queue runs empty
package serial_frame_pkg;
   // control word zero fields
   localparam int CR0_FRF_LSB = 4;
   localparam int CR0_PHASE_BIT = 6;
   localparam int CR0_POL_BIT = 7;
   localparam int CR0_MODE_LSB = 8;
   localparam int CR0_CLEN_LSB = 12;
   localparam int CR0_DFS_LSB = 16;
   localparam int CR0_TOGGLE_BIT = 24;
   // three-wire control fields
   localparam int MW_SEQ_BIT = 0;
   localparam int MW_DIR_BIT = 1;
   // frame length floor, as length minus one
   localparam logic [4:0] MIN_LEN_M1 = 5'h3;
   // pin levels at reset
   localparam logic SCLK_RESET = 1'h0;
   localparam logic SS_RESET = 1'h1;
   localparam logic TXD_RESET = 1'h0;
   typedef enum logic [1:0] {FMT_SPI, FMT_PULSE, FMT_THREE_WIRE, FMT_RSVD} frame_format_t;
   typedef enum logic [1:0] {TM_TX_RX, TM_TX_ONLY, TM_RX_ONLY, TM_MEM_READ} transfer_mode_t;
   typedef enum logic [2:0] {L_IDLE, L_LEAD, L_BITS, L_TAIL, L_GAP} link_state_t;
   typedef enum logic [1:0] {SEG_CTRL, SEG_DUMMY, SEG_DATA} segment_t;
endpackage

// >>> serial_slave_model.sv
// Purpose: behavioural serial slave facing the framing master
// Assumes: answer bits move only at select edges and on the edge opposite the master's sample edge
// Notes: logs the txd and rxd levels seen at every sample edge
`timescale 1ns/10ps
module serial_slave_model
   import serial_frame_pkg::*;
(
   input logic sclk_out,
   input logic ss_n,
   input logic txd,
   output logic rxd,
   input logic [31:0] control_register_zero,
   input logic [1:0] three_wire_control_reg
);
   logic samp_tx[$];
   logic samp_rx[$];
   int cnt = 0;
   int left = 0;
   logic [1:0] fmt;
   logic drv_lvl;
   int clen;
   int len;
   // sclk level during the driving half, per framing
   assign fmt = control_register_zero[CR0_FRF_LSB +: 2];
   assign drv_lvl = control_register_zero[CR0_POL_BIT] ^ ((fmt == 2'h0) ?
      control_register_zero[CR0_PHASE_BIT] : (fmt == 2'h1));
   assign clen = int'(control_register_zero[CR0_CLEN_LSB +: 4]);
   assign len = int'(control_register_zero[CR0_DFS_LSB +: 5]) + 1;
   // next answer bit; a read answer opens with a zero after the control word
   task automatic next_bit();
      int t;
      t = clen + len + 2;
      if (fmt == 2'h2 && !three_wire_control_reg[1] &&
         (three_wire_control_reg[0] ? cnt == clen + 1 : cnt % t == clen + 1))
         rxd = 1'b0;
      else
         rxd = 1'($urandom);
   endtask
   initial rxd = 1'b0;
   // drive edge moves the answer on, sample edge logs the pair; the marker
   // clock that opens a pulse-format burst carries no bit
   always @(sclk_out)
   begin
      if (sclk_out === drv_lvl)
         next_bit();
      else if (fmt == 2'h1 && left == 0)
         left = len;
      else
      begin
         samp_tx.push_back(txd);
         samp_rx.push_back(rxd);
         cnt++;
         // a marker during the last bit announces one more frame
         if (fmt == 2'h1)
            left = (left == 1 && ss_n === 1'b1) ? len : left - 1;
      end
   end
   // first bit before the first edge; line inverted when deselected
   always @(ss_n)
   begin
      if (fmt != 2'h1 && ss_n === 1'b0)
      begin
         cnt = 0;
         next_bit();
      end
      else if (fmt != 2'h1)
         rxd = ~rxd;
   end
endmodule // serial_slave_model

// >>> serial_master_frame_formats_bench.sv
// Purpose: self-checking bench of the serial master framing block
// Assumes: config changes only while the link is idle
// Notes: expected words are rebuilt from the bit pairs the slave model logged
`timescale 1ns/10ps
module serial_master_frame_formats_bench
   import serial_frame_pkg::*;
;
   logic clk = 0;
   logic link_clk = 0;
   logic rst_n = 0;
   logic [31:0] cr0 = '0;
   logic [1:0] twc = '0;
   logic [15:0] fc = '0;
   logic en = 0;
   logic [31:0] tx_data = '0;
   logic tx_valid = 0;
   logic tx_ready, rx_valid, busy, sclk_out, ss_n, txd, rxd;
   logic [31:0] rx_data;
   logic [31:0] got[$];
   int n_mismatch = 0;
   int checked = 0;
   int n_rise = 0;
   // system and link clocks, unrelated in phase
   always #50 clk = ~clk;
   always #62.5 link_clk = ~link_clk;
   serial_master_frame_formats i_serial_master_frame_formats (.clk(clk), .rst_n(rst_n),
      .link_clk(link_clk), .control_register_zero(cr0), .three_wire_control_reg(twc),
      .frame_count_reg(fc), .enable(en), .slave_enable(en), .tx_data(tx_data),
      .tx_valid(tx_valid), .tx_ready(tx_ready), .rx_data(rx_data), .rx_valid(rx_valid),
      .busy(busy), .sclk_out(sclk_out), .ss_n(ss_n), .txd(txd), .rxd(rxd));
   serial_slave_model i_serial_slave_model (.sclk_out(sclk_out), .ss_n(ss_n), .txd(txd),
      .rxd(rxd), .control_register_zero(cr0), .three_wire_control_reg(twc));
   // collect pushed words and select releases
   always @(negedge clk)
      if (rx_valid === 1'b1)
         got.push_back(rx_data);
   always @(posedge ss_n)
      n_rise++;
   task automatic test_done();
      if (n_mismatch == 0 && checked > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask
   task automatic cmp_word(input logic [31:0] g, input logic [31:0] e);
      checked++;
      if (g !== e)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   task automatic cmp_count(input int g, input int e);
      checked++;
      if (g != e)
      begin
         n_mismatch++;
         $display("wrong value at %0t: got %h expected %h", $time, g, e);
      end
   endtask
   // a word of logged bits, msb first
   function automatic logic [31:0] bits_of(input logic rx, input int p, input int n);
      logic [31:0] w;
      w = '0;
      for (int i = 0; i < n; i++)
         w = {w[30:0], rx ? i_serial_slave_model.samp_rx[p + i] :
            i_serial_slave_model.samp_tx[p + i]};
      return w;
   endfunction
   function automatic logic [31:0] cfg(input logic [1:0] fm, input logic ph, input logic pol,
      input logic [1:0] md, input logic [3:0] cf, input int ln, input logic tg);
      logic [31:0] c;
      c = '0;
      c[CR0_FRF_LSB +: 2] = fm;
      c[CR0_PHASE_BIT] = ph;
      c[CR0_POL_BIT] = pol;
      c[CR0_MODE_LSB +: 2] = md;
      c[CR0_CLEN_LSB +: 4] = cf;
      c[CR0_DFS_LSB +: 5] = 5'(ln - 1);
      c[CR0_TOGGLE_BIT] = tg;
      return c;
   endfunction
   // hand one word over when the holding stage is free
   task automatic send(input logic [31:0] w);
      int k;
      k = 0;
      while (tx_ready !== 1'b1 && k < 2000)
      begin
         @(negedge clk);
         k++;
      end
      if (k >= 2000)
         n_mismatch++;
      tx_data = w;
      tx_valid = 1'b1;
      @(negedge clk);
      tx_valid = 1'b0;
   endtask
   // one transfer: configure, send, wait idle, compare with the model
   task automatic run(input logic [31:0] c, input logic [1:0] tw, input logic [15:0] f,
      input int nw, input int nr);
      int ln, cl, t, nfr, tot, k, lk;
      logic [1:0] fm, md;
      int txp[$], txl[$], rxp[$];
      logic [31:0] ex[$], w;
      ln = int'(c[CR0_DFS_LSB +: 5]) + 1;
      cl = int'(c[CR0_CLEN_LSB +: 4]) + 1;
      fm = c[CR0_FRF_LSB +: 2];
      md = c[CR0_MODE_LSB +: 2];
      t = cl + 1 + ln;
      cr0 = c;
      twc = tw;
      fc = f;
      repeat (6) @(negedge clk);
      got.delete();
      i_serial_slave_model.samp_tx.delete();
      i_serial_slave_model.samp_rx.delete();
      n_rise = 0;
      for (k = 0; k < nw; k++)
      begin
         lk = (fm == 2'h2 && !(tw[1] && k == 1)) ? cl : ln;
         w = $urandom >> (32 - lk);
         if (!(fm != 2'h2 && md == 2'h2))
         begin
            txp.push_back(fm == 2'h2 ? (tw[1] ? k * cl : k * t) : k * ln);
            txl.push_back(lk);
            ex.push_back(w);
         end
         send(w);
      end
      // busy rises only a clock after the last word is taken
      repeat (2) @(negedge clk);
      k = 0;
      while (busy !== 1'b0 && k < 5000)
      begin
         @(negedge clk);
         k++;
      end
      if (k >= 5000)
         n_mismatch++;
      repeat (20) @(negedge clk);
      // where stored frames and sent words sit in the logged stream
      if (fm == 2'h2)
      begin
         nfr = tw[1] ? 0 : (tw[0] ? int'(f) + 1 : nw);
         for (k = 0; k < nfr; k++)
            rxp.push_back(tw[0] ? cl + 1 + k * ln : k * t + cl + 1);
         tot = tw[1] ? cl + ln : (tw[0] ? cl + 1 + nfr * ln : nw * t);
      end
      else
      begin
         nfr = md == 2'h2 ? int'(f) + 1 : (md == 2'h3 ? nw + int'(f) + 1 : nw);
         for (k = 0; k < nfr; k++)
         begin
            if (md == 2'h2)
            begin
               txp.push_back(k * ln);
               txl.push_back(ln);
               ex.push_back(32'h0);
            end
            if (md == 2'h0 || md == 2'h2 || (md == 2'h3 && k >= nw))
               rxp.push_back(k * ln);
         end
         tot = nfr * ln;
      end
      cmp_count(i_serial_slave_model.samp_tx.size(), tot);
      foreach (txp[i])
         cmp_word(bits_of(1'b0, txp[i], txl[i]), ex[i]);
      cmp_count(got.size(), rxp.size());
      foreach (rxp[i])
         cmp_word(got[i], bits_of(1'b1, rxp[i], ln));
      cmp_count(n_rise, nr);
      cmp_word(32'(sclk_out), 32'(c[CR0_POL_BIT]));
      cmp_word(32'(ss_n), (fm == 2'h1) ? 32'h0 : 32'h1);
   endtask
   initial
   begin
      void'($urandom(32'h33592111));
      repeat (3) @(negedge clk);
      rst_n = 1'b1;
      en = 1'b1;
      run(cfg(2'h0, 0, 0, 2'h0, 4'h0, 8, 1), 2'h0, 16'h0, 3, 3);
      run(cfg(2'h0, 1, 1, 2'h0, 4'h0, 8, 0), 2'h0, 16'h0, 2, 1);
      run(cfg(2'h0, 0, 1, 2'h1, 4'h0, 32, 0), 2'h0, 16'h0, 2, 1);
      run(cfg(2'h0, 1, 0, 2'h2, 4'h0, 4, 0), 2'h0, 16'h2, 1, 1);
      run(cfg(2'h0, 0, 0, 2'h3, 4'h0, 8, 0), 2'h0, 16'h1, 2, 1);
      run(cfg(2'h1, 0, 0, 2'h0, 4'h0, 12, 0), 2'h0, 16'h0, 2, 2);
      run(cfg(2'h2, 0, 0, 2'h0, 4'h7, 16, 0), 2'h2, 16'h0, 2, 1);
      run(cfg(2'h2, 0, 0, 2'h0, 4'hF, 8, 0), 2'h1, 16'h1, 1, 1);
      run(cfg(2'h2, 0, 0, 2'h0, 4'h0, 4, 0), 2'h0, 16'h0, 2, 1);
      test_done();
   end
   // watchdog against a hung transfer
   initial
   begin
      #3000000;
      n_mismatch++;
      test_done();
   end
endmodule // serial_master_frame_formats_bench
